// ---- logic/xform_regs.svh ----
`ifndef XFORM_REGS_SVH
`define XFORM_REGS_SVH

// data word width and fraction bits of every matrix term and coordinate
`define XF_DATA_W     32
`define XF_FRAC       16
// number of matrices the store can hold
`define XF_DEPTH      16
// width of command argument and variable address
`define XF_ARG_W      16
// term layout: nine rotation terms row-major, then three offset terms
`define XF_NUM_TERMS  12
`define XF_NUM_ROT    9
`define XF_DISP_BASE  9
`define XF_NUM_DISP   3
`define XF_NUM_AXES   3
// variable fetch counter width
`define XF_CNT_W      4

`endif

// ---- logic/xform_pkg.sv ----
package xform_pkg;

    // commands from the motion program executor
    typedef enum logic [3:0] {
        CMD_DEFINE   = 4'h0,  // allocate and clear matrix_store
        CMD_DELETE   = 4'h1,  // release matrix_store
        CMD_REINIT   = 4'h2,  // full reinitialisation
        CMD_SELECT   = 4'h3,  // select_matrix
        CMD_DESELECT = 4'h4,  // deselect_all_matrices
        CMD_IDENT    = 4'h5,  // matrix_to_identity
        CMD_LOAD_OFFSET_ABSOLUTE     = 4'h6,  // load_offset_absolute
        CMD_ADD_OFFSET_INCREMENTAL     = 4'h7,  // add_offset_incremental
        CMD_LOAD_ROTATION_ABSOLUTE     = 4'h8,  // load_rotation_absolute
        CMD_MULTIPLY_ROTATION_INCREMENTAL     = 4'h9   // multiply_rotation_incremental
    } cmd_type;

    // sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_FILL  = 6'h02,
        ST_FETCH = 6'h04,
        ST_VARS  = 6'h08,
        ST_APPLY = 6'h10,
        ST_WRITE = 6'h20
    } state_type;

endpackage

// ---- logic/matrix_mem_if.sv ----
`timescale 1ns/100ps
`default_nettype none

// port between the sequencer and the matrix store
interface matrix_mem_if #(
    parameter int AW = 4,
    parameter int MW = 384
);
    logic          wr_en;    // write one whole matrix
    logic [AW-1:0] wr_addr;  // matrix slot written
    logic [MW-1:0] wr_data;  // packed terms
    logic          rd_en;    // read request
    logic [AW-1:0] rd_addr;  // matrix slot read
    logic [MW-1:0] rd_data;  // registered read data, next cycle

    modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
    modport mem  (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface

`default_nettype wire

// ---- logic/matrix_store_mem.sv ----
`timescale 1ns/100ps
`default_nettype none

// matrix storage; no reset so contents survive resetn, standing in for
// the battery-backed store. define fills it; initialise, offset and rotation commands write back the selected slot.
module matrix_store_mem #(
    parameter int DEPTH = 16,
    parameter int AW    = 4,
    parameter int MW    = 384
) (
    input  wire logic  core_clk,
    matrix_mem_if.mem  mport
);

    logic [MW-1:0] store [0:DEPTH-1];  // one packed matrix per slot

    // single write port, registered read port
    always_ff @(posedge core_clk) begin
        if (mport.wr_en) begin
            store[mport.wr_addr] <= mport.wr_data;
        end
        if (mport.rd_en) begin
            mport.rd_data <= store[mport.rd_addr];
        end
    end

endmodule

`default_nettype wire

// ---- logic/axis_transform_matrix_unit.sv ----
// Function
// [RULE_01] output equals matrix times base plus offset
// [RULE_02] base coordinates come from fixed axis definitions
// [RULE_03] define allocates count matrices, all identity
// [RULE_04] store kept until delete or reinitialise
// [RULE_05] select makes indexed matrix active for moves
// [RULE_06] moves use matrix contents as they stand
// [RULE_07] initialise sets selected matrix to identity
// [RULE_08] absolute offset loads variables n..n+2
// [RULE_09] incremental offset adds variables n..n+2
// [RULE_10] absolute rotation loads n..n+8 row-major
// [RULE_11] incremental rotation multiplies by variables n..n+8
// [RULE_12] variables copied only when command executes
// [RULE_13] deselect bypasses all transform computation
// [RULE_14] uncommanded axes hold transformed existing position
// [RULE_15] program uses centre vector, not radius, when scaling
// [RULE_16] select beyond allocated count rejected, selection kept
`include "xform_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module axis_transform_matrix_unit #(
    parameter int W     = `XF_DATA_W,
    parameter int FRAC  = `XF_FRAC,
    parameter int DEPTH = `XF_DEPTH,
    parameter int AGW   = `XF_ARG_W
) (
    input  wire logic                core_clk,
    input  wire logic                resetn,
    input  wire logic                cmd_valid,
    output logic                     cmd_ready,
    input  wire xform_pkg::cmd_type  cmd_op,
    input  wire logic [AGW-1:0]      cmd_arg,
    output logic                     cmd_done,
    output logic                     cmd_error,
    output logic                     var_rd,
    output logic [AGW-1:0]           var_addr,
    input  wire logic signed [W-1:0] var_data,
    input  wire logic                move_valid,
    output logic                     move_ready,
    input  wire logic                move_abs,
    input  wire logic [2:0]          move_mask,
    input  wire logic signed [W-1:0] move_x,
    input  wire logic signed [W-1:0] move_y,
    input  wire logic signed [W-1:0] move_z,
    output logic                     res_valid,
    output logic signed [W-1:0]      res_x,
    output logic signed [W-1:0]      res_y,
    output logic signed [W-1:0]      res_z,
    output logic                     xform_active,
    output logic [$clog2(DEPTH):0]   matrix_count
);

    localparam int AW = $clog2(DEPTH);
    localparam int NT = `XF_NUM_TERMS;
    localparam int MW = NT * W;
    localparam int CW = `XF_CNT_W;
    localparam logic signed [W-1:0] ONE = W'(1) <<< FRAC;  // fixed-point 1.0

    xform_pkg::state_type state_reg;     // sequencer state
    xform_pkg::cmd_type   op_reg;        // command being carried out
    logic [AW:0]          count_reg;     // allocated matrices
    logic [AW-1:0]        sel_idx_reg;   // selected slot, zero-based
    logic                 sel_valid_reg; // a matrix is selected
    logic [AW-1:0]        fill_idx_reg;  // slot being cleared by define
    logic [CW-1:0]        issue_cnt_reg; // variable reads issued
    logic [CW-1:0]        recv_cnt_reg;  // variable words captured
    logic [CW-1:0]        need_cnt_reg;  // 3 or 9 words for this command
    logic                 pend_reg;      // read data arrives this cycle
    logic [AGW-1:0]       var_addr_reg;  // next variable address
    logic signed [W-1:0]  act_reg  [0:NT-1];            // active matrix copy
    logic signed [W-1:0]  act_next [0:NT-1];            // value after apply
    logic signed [W-1:0]  qv_reg   [0:`XF_NUM_ROT-1];   // captured variables
    logic signed [W-1:0]  rp       [0:`XF_NUM_ROT-1];   // rotation product
    logic signed [W-1:0]  base_reg [0:`XF_NUM_AXES-1];  // last untransformed pos
    logic signed [W-1:0]  b        [0:`XF_NUM_AXES-1];  // base for this move
    logic signed [W-1:0]  mv       [0:`XF_NUM_AXES-1];  // move inputs by axis
    logic signed [W-1:0]  tout     [0:`XF_NUM_AXES-1];  // transformed output
    logic                 idle;                         // sequencer free
    logic                 take_cmd;                     // command accepted now
    logic                 take_move;                    // move accepted now

    matrix_mem_if #(.AW(AW), .MW(MW)) mif ();

    matrix_store_mem #(.DEPTH(DEPTH), .AW(AW), .MW(MW)) u_store (
        .core_clk (core_clk),
        .mport    (mif.mem)
    );

    // commands go first; a move waits while any command is pending
    assign idle       = (state_reg == xform_pkg::ST_IDLE);
    assign cmd_ready  = idle;
    assign move_ready = idle && !cmd_valid;
    assign take_cmd   = cmd_valid && cmd_ready;
    assign take_move  = move_valid && move_ready;
    assign var_rd     = (state_reg == xform_pkg::ST_VARS) && (issue_cnt_reg < need_cnt_reg);
    assign var_addr   = var_addr_reg;
    assign xform_active = sel_valid_reg;
    assign matrix_count = count_reg;
    assign mv[0] = move_x;
    assign mv[1] = move_y;
    assign mv[2] = move_z;

    // store port: define writes identity slots, commands write back the copy
    assign mif.wr_en   = (state_reg == xform_pkg::ST_FILL) || (state_reg == xform_pkg::ST_WRITE);
    assign mif.wr_addr = (state_reg == xform_pkg::ST_FILL) ? fill_idx_reg : sel_idx_reg;
    assign mif.rd_en   = take_cmd && (cmd_op == xform_pkg::CMD_SELECT);
    assign mif.rd_addr = AW'(cmd_arg - AGW'(1));

    genvar e, r, c;

    // per-term packing, apply logic and the active copy itself
    generate
        for (e = 0; e < NT; e++) begin : g_term
            localparam logic signed [W-1:0] IDV = (e == 0 || e == 4 || e == 8) ? ONE : '0;
            assign mif.wr_data[e*W +: W] = (state_reg == xform_pkg::ST_FILL) ? IDV : act_reg[e];  // RULE_03
            always_comb begin
                act_next[e] = act_reg[e];
                if (e >= `XF_DISP_BASE) begin
                    if (op_reg == xform_pkg::CMD_LOAD_OFFSET_ABSOLUTE) begin
                        act_next[e] = qv_reg[e-`XF_DISP_BASE];  // RULE_08
                    end else if (op_reg == xform_pkg::CMD_ADD_OFFSET_INCREMENTAL) begin
                        act_next[e] = act_reg[e] + qv_reg[e-`XF_DISP_BASE];  // RULE_09
                    end
                end else begin
                    if (op_reg == xform_pkg::CMD_LOAD_ROTATION_ABSOLUTE) begin
                        act_next[e] = qv_reg[e];  // RULE_10
                    end else if (op_reg == xform_pkg::CMD_MULTIPLY_ROTATION_INCREMENTAL) begin
                        act_next[e] = rp[e];  // RULE_11
                    end
                end
            end
            // the copy changes only on select, initialise or apply
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    act_reg[e] <= IDV;
                end else if (state_reg == xform_pkg::ST_FETCH) begin
                    act_reg[e] <= mif.rd_data[e*W +: W];  // RULE_05
                end else if (take_cmd && cmd_op == xform_pkg::CMD_IDENT && sel_valid_reg) begin
                    act_reg[e] <= IDV;  // RULE_07
                end else if (state_reg == xform_pkg::ST_APPLY) begin
                    act_reg[e] <= act_next[e];  // RULE_12
                end
            end
        end

        // existing rotation times the variable matrix, row by column
        for (r = 0; r < 3; r++) begin : g_row
            for (c = 0; c < 3; c++) begin : g_col
                logic signed [2*W-1:0] acc;  // full-width sum before rescale
                assign acc = act_reg[r*3] * qv_reg[c] + act_reg[r*3+1] * qv_reg[3+c]
                           + act_reg[r*3+2] * qv_reg[6+c];
                assign rp[r*3+c] = W'(acc >>> FRAC);  // RULE_11
            end
        end

        // per axis: pick base, transform, hold last base
        for (r = 0; r < `XF_NUM_AXES; r++) begin : g_axis
            logic signed [2*W-1:0] msum;  // row dot product
            // an uncommanded axis keeps its old base, so its output is the
            // old position under the current transform
            assign b[r] = !move_mask[r] ? base_reg[r] :
                          (move_abs ? mv[r] : base_reg[r] + mv[r]);  // RULE_14
            assign msum = act_reg[r*3] * b[0] + act_reg[r*3+1] * b[1] + act_reg[r*3+2] * b[2];  // RULE_02
            // deselected: pass through, no multiply result used
            assign tout[r] = sel_valid_reg ? W'(msum >>> FRAC) + act_reg[`XF_DISP_BASE+r] : b[r];  // RULE_01 RULE_13
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    base_reg[r] <= '0;
                end else if (take_move) begin
                    base_reg[r] <= b[r];
                end
            end
        end
    endgenerate

    // move results, registered; contents used as they stand now
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            res_valid <= 1'b0;
            res_x     <= '0;
            res_y     <= '0;
            res_z     <= '0;
        end else begin
            res_valid <= take_move;
            if (take_move) begin
                res_x <= tout[0];  // RULE_06
                res_y <= tout[1];
                res_z <= tout[2];
            end
        end
    end

    // captured variables; written only while a command fetches them
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < `XF_NUM_ROT; i++) begin
                qv_reg[i] <= '0;
            end
        end else if (pend_reg) begin
            qv_reg[recv_cnt_reg] <= var_data;  // RULE_12
        end
    end

    // variable read sequencing: one word per cycle, data one cycle later
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            issue_cnt_reg <= '0;
            recv_cnt_reg  <= '0;
            pend_reg      <= 1'b0;
            var_addr_reg  <= '0;
        end else if (take_cmd) begin
            issue_cnt_reg <= '0;
            recv_cnt_reg  <= '0;
            pend_reg      <= 1'b0;
            var_addr_reg  <= cmd_arg;
        end else begin
            pend_reg <= var_rd;
            if (var_rd) begin
                issue_cnt_reg <= issue_cnt_reg + CW'(1);
                var_addr_reg  <= var_addr_reg + AGW'(1);  // RULE_08 RULE_10
            end
            if (pend_reg) begin
                recv_cnt_reg <= recv_cnt_reg + CW'(1);
            end
        end
    end

    // command sequencer, allocation and selection
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg     <= xform_pkg::ST_IDLE;
            op_reg        <= xform_pkg::CMD_DESELECT;
            count_reg     <= '0;
            sel_idx_reg   <= '0;
            sel_valid_reg <= 1'b0;
            fill_idx_reg  <= '0;
            need_cnt_reg  <= '0;
            cmd_done      <= 1'b0;
            cmd_error     <= 1'b0;
        end else begin
            cmd_done  <= 1'b0;
            cmd_error <= 1'b0;
            case (state_reg)
                xform_pkg::ST_IDLE: begin
                    if (take_cmd) begin
                        op_reg       <= cmd_op;
                        need_cnt_reg <= (cmd_op == xform_pkg::CMD_LOAD_ROTATION_ABSOLUTE || cmd_op == xform_pkg::CMD_MULTIPLY_ROTATION_INCREMENTAL)
                                        ? CW'(`XF_NUM_ROT) : CW'(`XF_NUM_DISP);
                        case (cmd_op)
                            xform_pkg::CMD_DEFINE: begin
                                if (cmd_arg == '0 || cmd_arg > AGW'(DEPTH)) begin
                                    cmd_error <= 1'b1;
                                end else begin
                                    count_reg     <= (AW+1)'(cmd_arg);  // RULE_03
                                    sel_valid_reg <= 1'b0;
                                    fill_idx_reg  <= '0;
                                    state_reg     <= xform_pkg::ST_FILL;
                                end
                            end
                            xform_pkg::CMD_DELETE, xform_pkg::CMD_REINIT: begin
                                count_reg     <= '0;  // RULE_04
                                sel_valid_reg <= 1'b0;
                                cmd_done      <= 1'b1;
                            end
                            xform_pkg::CMD_SELECT: begin
                                if (cmd_arg == '0 || cmd_arg > AGW'(count_reg)) begin
                                    cmd_error <= 1'b1;  // RULE_16
                                end else begin
                                    sel_idx_reg <= AW'(cmd_arg - AGW'(1));
                                    state_reg   <= xform_pkg::ST_FETCH;  // RULE_05
                                end
                            end
                            xform_pkg::CMD_DESELECT: begin
                                sel_valid_reg <= 1'b0;  // RULE_13
                                cmd_done      <= 1'b1;
                            end
                            xform_pkg::CMD_IDENT: begin
                                if (!sel_valid_reg) begin
                                    cmd_error <= 1'b1;
                                end else begin
                                    state_reg <= xform_pkg::ST_WRITE;  // RULE_07
                                end
                            end
                            default: begin
                                // offset and rotation loads need a selection
                                if (!sel_valid_reg || cmd_op > xform_pkg::CMD_MULTIPLY_ROTATION_INCREMENTAL) begin
                                    cmd_error <= 1'b1;
                                end else begin
                                    state_reg <= xform_pkg::ST_VARS;
                                end
                            end
                        endcase
                    end
                end
                xform_pkg::ST_FILL: begin
                    // one slot per cycle; count_reg is at least one here
                    if ((AW+1)'(fill_idx_reg) == count_reg - (AW+1)'(1)) begin
                        cmd_done  <= 1'b1;
                        state_reg <= xform_pkg::ST_IDLE;
                    end else begin
                        fill_idx_reg <= fill_idx_reg + AW'(1);
                    end
                end
                xform_pkg::ST_FETCH: begin
                    sel_valid_reg <= 1'b1;  // RULE_05
                    cmd_done      <= 1'b1;
                    state_reg     <= xform_pkg::ST_IDLE;
                end
                xform_pkg::ST_VARS: begin
                    if (pend_reg && recv_cnt_reg == need_cnt_reg - CW'(1)) begin
                        state_reg <= xform_pkg::ST_APPLY;
                    end
                end
                xform_pkg::ST_APPLY: begin
                    state_reg <= xform_pkg::ST_WRITE;
                end
                xform_pkg::ST_WRITE: begin
                    // store now matches the copy, so a later reselect sees it
                    cmd_done  <= 1'b1;
                    state_reg <= xform_pkg::ST_IDLE;
                end
                default: begin
                    state_reg <= xform_pkg::ST_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ---- test/axis_transform_matrix_unit_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
// pin-level watcher for the transform unit
module axis_transform_matrix_unit_chk #(
    parameter int W     = 32,
    parameter int DEPTH = 16,
    parameter int AGW   = 16
) (
    input wire logic                 core_clk,
    input wire logic                 resetn,
    input wire logic                 cmd_valid,
    input wire logic                 cmd_ready,
    input wire xform_pkg::cmd_type   cmd_op,
    input wire logic [AGW-1:0]       cmd_arg,
    input wire logic                 cmd_done,
    input wire logic                 cmd_error,
    input wire logic                 var_rd,
    input wire logic [AGW-1:0]       var_addr,
    input wire logic                 move_valid,
    input wire logic                 move_ready,
    input wire logic                 move_abs,
    input wire logic [2:0]           move_mask,
    input wire logic signed [W-1:0]  move_x,
    input wire logic signed [W-1:0]  move_y,
    input wire logic signed [W-1:0]  move_z,
    input wire logic                 res_valid,
    input wire logic signed [W-1:0]  res_x,
    input wire logic signed [W-1:0]  res_y,
    input wire logic signed [W-1:0]  res_z,
    input wire logic                 xform_active,
    input wire logic [$clog2(DEPTH):0] matrix_count
);
    logic           take;    // command accepted at this edge
    logic           mtake;   // move accepted at this edge
    logic [AGW-1:0] arg_reg; // argument of the last taken command
    assign take  = cmd_valid && cmd_ready;
    assign mtake = move_valid && move_ready;
    // safe to keep one copy: no new take before the answer
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            arg_reg <= '0;
        end else if (take) begin
            arg_reg <= cmd_arg;
        end
    end
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_define_count: assert property (
        take && cmd_op == xform_pkg::CMD_DEFINE && cmd_arg != '0 && cmd_arg <= DEPTH
        |-> ##[2:17] cmd_done ##1 matrix_count == arg_reg[$clog2(DEPTH):0]) else $error("define count wrong");
    a_delete_clear: assert property (
        take && (cmd_op == xform_pkg::CMD_DELETE || cmd_op == xform_pkg::CMD_REINIT)
        |=> cmd_done ##1 (matrix_count == '0 && !xform_active)) else $error("store not released");
    a_select_active: assert property (
        take && cmd_op == xform_pkg::CMD_SELECT && cmd_arg != '0 && cmd_arg <= matrix_count
        |-> ##2 cmd_done ##1 xform_active) else $error("select not taken");
    a_select_reject: assert property (
        take && cmd_op == xform_pkg::CMD_SELECT && (cmd_arg == '0 || cmd_arg > matrix_count)
        |=> cmd_error ##1 xform_active == $past(xform_active, 2)) else $error("bad select accepted");
    a_offset_reads: assert property (
        take && (cmd_op == xform_pkg::CMD_LOAD_OFFSET_ABSOLUTE || cmd_op == xform_pkg::CMD_ADD_OFFSET_INCREMENTAL) && xform_active
        |=> var_rd && var_addr == arg_reg ##1 var_rd && var_addr == arg_reg + 1'b1
        ##1 var_rd && var_addr == arg_reg + 2'h2 ##1 !var_rd ##3 cmd_done) else $error("offset fetch wrong");
    a_rotation_reads: assert property (
        take && (cmd_op == xform_pkg::CMD_LOAD_ROTATION_ABSOLUTE || cmd_op == xform_pkg::CMD_MULTIPLY_ROTATION_INCREMENTAL) && xform_active
        |=> var_rd && var_addr == arg_reg ##1 var_rd [*7] ##1 var_rd && var_addr == arg_reg + 4'h8
        ##1 !var_rd ##3 cmd_done) else $error("rotation fetch wrong");
    a_deselect_off: assert property (
        take && cmd_op == xform_pkg::CMD_DESELECT |=> cmd_done ##1 !xform_active) else $error("still selected");
    a_move_plain: assert property (
        mtake && !xform_active && move_abs && move_mask == 3'h7 |=> res_valid && res_x == $past(move_x)
        && res_y == $past(move_y) && res_z == $past(move_z)) else $error("bypass result wrong");
endmodule
bind axis_transform_matrix_unit axis_transform_matrix_unit_chk #(.W(W), .DEPTH(DEPTH), .AGW(AGW)) i_chk (.*);
`default_nettype wire

// ---- test/variable_store.sv ----
`timescale 1ns/100ps
`default_nettype none
// executor's variable file, fixed one-cycle read latency
module variable_store (
    input  wire logic          core_clk,
    input  wire logic          var_rd,
    input  wire logic [15:0]   var_addr,
    output var logic signed [31:0] var_data
);
    logic signed [31:0] q [0:255]; // variables, written by the bench
    initial begin
        var_data = '0;
        foreach (q[k]) q[k] = '0;
    end
    // flips between reads so stale data shows up
    always @(posedge core_clk) begin
        if (var_rd) begin
            var_data <= q[var_addr[7:0]];
        end else begin
            var_data <= ~var_data;
        end
    end
endmodule
`default_nettype wire

// ---- test/tb_axis_transform_matrix_unit.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_axis_transform_matrix_unit;
    logic               core_clk, resetn, cmd_valid, cmd_ready, cmd_done, cmd_error, var_rd;
    logic               move_valid, move_ready, move_abs, res_valid, xform_active;
    xform_pkg::cmd_type cmd_op;
    logic [15:0]        cmd_arg, var_addr;
    logic [2:0]         move_mask;
    logic [4:0]         matrix_count;
    logic signed [31:0] var_data, move_x, move_y, move_z, res_x, res_y, res_z;
    int                 fails, n_compared, cyc, i;
    axis_transform_matrix_unit i_axis_transform_matrix_unit (.*);
    variable_store i_variable_store (.*);
    // q16.16 value of a whole number
    function automatic logic [31:0] fx(input int k);
        return 32'(k * 65536);
    endfunction
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // hold until taken, then judge the answer pulse
    task automatic cmd(input xform_pkg::cmd_type op, input logic [15:0] arg, input logic err);
        @(negedge core_clk);
        cmd_op = op;
        cmd_arg = arg;
        cmd_valid = 1'b1;
        while (!cmd_ready) @(negedge core_clk);
        @(negedge core_clk);
        cmd_valid = 1'b0;
        while (!(cmd_done || cmd_error)) @(negedge core_clk);
        chk("cmd_error", 32'(cmd_error), 32'(err));
        @(negedge core_clk);
    endtask
    // one move, result must show one cycle after the take
    task automatic mv(input logic ab, input logic [2:0] m, input logic [31:0] x, y, z, ex, ey, ez);
        @(negedge core_clk);
        {move_abs, move_mask, move_x, move_y, move_z} = {ab, m, x, y, z};
        move_valid = 1'b1;
        while (!move_ready) @(negedge core_clk);
        @(negedge core_clk);
        move_valid = 1'b0;
        chk("res_valid", 32'(res_valid), 32'h1);
        chk("res_x", res_x, ex);
        chk("res_y", res_y, ey);
        chk("res_z", res_z, ez);
    endtask
    task automatic s_refuse;
        cmd(xform_pkg::CMD_SELECT, 16'h0001, 1'b1);
        cmd(xform_pkg::CMD_IDENT, 16'h0000, 1'b1);
        cmd(xform_pkg::CMD_DEFINE, 16'h0000, 1'b1);
        cmd(xform_pkg::CMD_DEFINE, 16'h0011, 1'b1);
    endtask
    task automatic s_define;
        cmd(xform_pkg::CMD_DEFINE, 16'h0002, 1'b0);
        chk("matrix_count", 32'(matrix_count), 32'h2);
        cmd(xform_pkg::CMD_SELECT, 16'h0003, 1'b1);
        chk("xform_active", 32'(xform_active), 32'h0);
        cmd(xform_pkg::CMD_SELECT, 16'h0002, 1'b0);
        chk("xform_active", 32'(xform_active), 32'h1);
        mv(1'b1, 3'h7, fx(1), fx(2), fx(3), fx(1), fx(2), fx(3));
    endtask
    // offsets land per axis, later variable writes leave the matrix alone
    task automatic s_offset;
        for (i = 0; i < 3; i++) i_variable_store.q[25+i] = fx(i + 1);
        cmd(xform_pkg::CMD_LOAD_OFFSET_ABSOLUTE, 16'h0019, 1'b0);
        mv(1'b1, 3'h7, 0, 0, 0, fx(1), fx(2), fx(3));
        cmd(xform_pkg::CMD_ADD_OFFSET_INCREMENTAL, 16'h0019, 1'b0);
        i_variable_store.q[25] = fx(100);
        mv(1'b1, 3'h7, 0, 0, 0, fx(2), fx(4), fx(6));
    endtask
    // a permutation shows row order, a scale on the right shows product order
    task automatic s_rotate;
        for (i = 0; i < 9; i++) i_variable_store.q[71+i] = (i == 1 || i == 5 || i == 6) ? fx(1) : 0;
        for (i = 0; i < 9; i++) i_variable_store.q[100+i] = (i == 0) ? fx(2) : (i % 4 == 0) ? fx(1) : 0;
        cmd(xform_pkg::CMD_LOAD_ROTATION_ABSOLUTE, 16'h0047, 1'b0);
        mv(1'b1, 3'h7, fx(1), fx(2), fx(3), fx(4), fx(7), fx(7));
        cmd(xform_pkg::CMD_MULTIPLY_ROTATION_INCREMENTAL, 16'h0064, 1'b0);
        mv(1'b1, 3'h1, 0, 0, 0, fx(4), fx(7), fx(6));
    endtask
    task automatic s_teardown;
        cmd(xform_pkg::CMD_DESELECT, 16'h0000, 1'b0);
        mv(1'b0, 3'h7, fx(1), fx(1), fx(1), fx(1), fx(3), fx(4));
        cmd(xform_pkg::CMD_IDENT, 16'h0000, 1'b1);
        cmd(xform_pkg::CMD_SELECT, 16'h0002, 1'b0);
        mv(1'b1, 3'h7, fx(1), fx(2), fx(3), fx(4), fx(7), fx(8));
        cmd(xform_pkg::CMD_IDENT, 16'h0000, 1'b0);
        mv(1'b1, 3'h7, fx(1), fx(2), fx(3), fx(1), fx(2), fx(3));
        cmd(xform_pkg::CMD_DELETE, 16'h0000, 1'b0);
        cmd(xform_pkg::CMD_SELECT, 16'h0001, 1'b1);
        cmd(xform_pkg::CMD_DEFINE, 16'h0001, 1'b0);
        cmd(xform_pkg::CMD_REINIT, 16'h0000, 1'b0);
        chk("matrix_count", 32'(matrix_count), 32'h0);
    endtask
    task automatic complete_run;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // run needs under a thousand
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            complete_run();
        end
    end
    initial begin
        {resetn, cmd_valid, move_valid, move_abs, move_mask, cmd_arg} = '0;
        {move_x, move_y, move_z} = '0;
        cmd_op = xform_pkg::CMD_DEFINE;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        resetn = 1'b1;
        s_refuse();
        s_define();
        s_offset();
        s_rotate();
        s_teardown();
        complete_run();
    end
endmodule
`default_nettype wire
